// ### common/emrt_pkg.sv
// Shared constants and types for the readout routing and timing pair.
// Assumes one 10 MHz clock on both ends; sample words are digitised electron counts.
// Behaviour
// - Barriers stay low until receiving store high
// - Store b falls as store a rises
// - Barrier rises only after its store high
// - Barrier falls before its store falls
// - Multiplying register depth fixes multiplied latency
// - Switch gate timing picks route per pixel
// - Threshold near 150 electrons, small to multiplier
// - Pixel period never under minimum time
// - Clamp only within first row cycles
// - First active pixel at sense after 36
// - First active pixel at normal after 68
// - First active pixel at multiplied after 64
// - Full line: 3084 cycles, one line lag
// - Split line: 1542 cycles, two line lag
// - Mult route clocks mult gate, else normal
// - Route applied 28 cycles after sensing
// - Row transfer parks phase one high, two low
package emrt_pkg;

  // Data widths
  localparam int CHARGE_W = 16;                 // Electron count per packet
  localparam int CNT_W    = 12;                 // Pixel counter width
  localparam int TICK_W   = 3;                  // Clock ticks within one pixel
  localparam int ROW_W    = 5;                  // Row transfer tick counter

  // Charge path figures, in horizontal cycles
  localparam int MULT_STAGES  = 1800;           // Multiplying transfers per quadrant
  localparam int SENSE_DELAY  = 36;             // Row transfer to sense output
  localparam int MULT_DELAY   = 64;             // Row transfer to multiplied output
  localparam int NORMAL_DELAY = 68;             // Row transfer to normal output
  localparam int ROUTE_DELAY  = 28;             // Sense to charge switch
  localparam int CLAMP_CYCLES = 28;             // Clamp window at row start
  localparam int LINE_FULL    = 3084;           // Whole line to left outputs
  localparam int LINE_SPLIT   = 1542;           // Half lines split left and right
  localparam int THRESH_DEFAULT = 150;          // Suggested route threshold, electrons

  // Derived pipeline shapes
  localparam int HCCD_STAGES = SENSE_DELAY + ROUTE_DELAY - 1;  // Stages ahead of the switch
  localparam int NORM_STAGES = NORMAL_DELAY - MULT_DELAY;      // Stages after switch, normal
  localparam int EM_DEPTH    = LINE_FULL;                      // Cells after switch, multiplied
  localparam int EM_W        = 12;                             // Pointer width into EM cells

  // Pixel and row timing
  localparam int CLK_PERIOD_NS  = 100;          // I_CLK period
  localparam int PIX_MIN_NS     = 50;           // Least time for one pixel
  localparam int PIX_MIN_RAW    = (PIX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIX_MIN_CYCLES = (PIX_MIN_RAW < 1) ? 1 : PIX_MIN_RAW;
  localparam int PIX_TICKS      = 8;            // Gate sequence length per pixel
  localparam int ROW_XFER_TICKS = 16;           // Horizontal clocks stopped this long

  localparam logic [TICK_W-1:0] TICK_LAST   =
    TICK_W'(((PIX_TICKS > PIX_MIN_CYCLES) ? PIX_TICKS : PIX_MIN_CYCLES) - 1);
  localparam logic [TICK_W-1:0] LHG_ON_TICK = 3'h4;  // Phase two high from here
  localparam logic [TICK_W-1:0] SAMPLE_TICK = 3'h3;  // Sense output read here
  localparam logic [ROW_W-1:0]  ROW_LAST    = ROW_W'(ROW_XFER_TICKS - 1);

  // Multiplier gate pattern per tick, bits {store_a, barrier_a, store_b, barrier_b}
  localparam logic [3:0] GATE_SEQ [0:7] =
    '{4'h8, 4'hA, 4'hB, 4'h3, 4'h2, 4'h8, 4'hC, 4'h8};
  localparam logic [3:0] PARK_GATES = 4'hC;       // Phase one high, phase two low

  // Line organisation
  typedef enum logic {
    MODE_FULL  = 1'b0,
    MODE_SPLIT = 1'b1
  } emrt_mode_e;

  // Timing generator sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ROW  = 2'b01,
    ST_LINE = 2'b10
  } emrt_state_e;

endpackage

// ### common/emrt_link_if.sv
// Link between the camera timing generator and one sensor quadrant.
// Assumes both ends share I_CLK; all signals are plain levels.
`timescale 1ns/1ps
interface emrt_link_if;
  import emrt_pkg::*;

  // Gates driven by the timing generator
  logic                row_transfer;            // Vertical row transfer in progress
  logic                mult_store_gate_a;       // Multiplier store phase a
  logic                mult_barrier_gate_a;     // Multiplier barrier phase a
  logic                mult_store_gate_b;       // Multiplier store phase b
  logic                mult_barrier_gate_b;     // Multiplier barrier phase b
  logic                last_horizontal_gate;    // Falling edge moves every packet
  logic                switch_gate_normal_path; // Clocked to route to normal output
  logic                switch_gate_mult_path;   // Clocked to route to multiplier
  // Digitised outputs from the sensor side
  logic [CHARGE_W-1:0] threshold_sense_output;  // Non-destructive sense sample
  logic [CHARGE_W-1:0] normal_gain_output;      // Normal gain path
  logic [CHARGE_W-1:0] multiplied_output;       // Multiplied path

  // Timing generator end
  modport gen (
    output row_transfer, mult_store_gate_a, mult_barrier_gate_a, mult_store_gate_b,
    output mult_barrier_gate_b, last_horizontal_gate,
    output switch_gate_normal_path, switch_gate_mult_path,
    input  threshold_sense_output, normal_gain_output, multiplied_output
  );

  // Sensor end
  modport dev (
    input  row_transfer, mult_store_gate_a, mult_barrier_gate_a, mult_store_gate_b,
    input  mult_barrier_gate_b, last_horizontal_gate,
    input  switch_gate_normal_path, switch_gate_mult_path,
    output threshold_sense_output, normal_gain_output, multiplied_output
  );

endinterface

// ### hw/emrt_sensor_quad.sv
// Sensor quadrant end: horizontal register, sense stage, charge switch, outputs.
// Assumes gates arrive synchronous to I_CLK; one packet enters per falling phase two.
`timescale 1ns/1ps
module emrt_sensor_quad import emrt_pkg::*; #(
  parameter int MULT_GAIN = 4                       // Plain gain of the multiplied path
) (
  // Clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RST,
  // Link
  emrt_link_if.dev                 LINK,
  // Charge source and mode
  input  wire logic [CHARGE_W-1:0] I_CHARGE,
  input  wire logic                I_SPLIT,
  input  wire logic                I_ERR_CLR,
  // Observation
  output      logic                O_SHIFT,
  output      logic                O_ALIGN_ERR,
  output      logic                O_ORDER_ERR,
  output      logic                O_PARK_ERR,
  output      logic                O_ROUTE_ERR
);

  logic                lhg_q;                      // Phase two, last cycle
  logic                row_q;                      // Row transfer, last cycle
  logic [3:0]          gate_q;                     // Multiplier gates, last cycle
  logic [3:0]          gate_now;                   // Multiplier gates, this cycle
  logic                shift;                      // One packet step
  logic                seen_norm;                  // Normal gate clocked this pixel
  logic                seen_mult;                  // Multiplier gate clocked this pixel
  logic [CHARGE_W-1:0] chain [0:HCCD_STAGES-1];    // Register ahead of the switch
  logic [CHARGE_W-1:0] nrm [0:NORM_STAGES-1];      // Normal path stages
  logic [CHARGE_W-1:0] em_mem [0:EM_DEPTH-1];      // Multiplying register cells
  logic [EM_W-1:0]     em_ptr;                     // Oldest cell
  logic                em_full;                    // Cells hold real charge
  logic [CHARGE_W-1:0] sense_out;                  // Sense stage value
  logic [CHARGE_W-1:0] norm_out;                   // Normal output register
  logic [CHARGE_W-1:0] mult_out;                   // Multiplied output register
  logic [CNT_W-1:0]    line_cnt;                   // Steps since row transfer
  logic [CHARGE_W+7:0] gain_prod;                  // Unsaturated product
  logic                order_bad;
  logic                park_bad;
  logic                line_split;                 // Mode latched when this line began
  logic [CNT_W-1:0]    line_total;                 // Steps including one at row start

  assign gate_now = {LINK.mult_store_gate_a, LINK.mult_barrier_gate_a,
                     LINK.mult_store_gate_b, LINK.mult_barrier_gate_b};
  // Charge moves on the falling edge of the last horizontal gate
  assign shift    = lhg_q & ~LINK.last_horizontal_gate;
  assign O_SHIFT  = shift;
  assign sense_out = chain[SENSE_DELAY-1];
  assign LINK.threshold_sense_output = sense_out;
  assign LINK.normal_gain_output     = norm_out;
  assign LINK.multiplied_output      = mult_out;

  // Edge history of the link
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      lhg_q  <= 1'b0;
      row_q  <= 1'b0;
      gate_q <= PARK_GATES;
    end else begin
      lhg_q  <= LINK.last_horizontal_gate;
      row_q  <= LINK.row_transfer;
      gate_q <= gate_now;
    end
  end

  // Route flags gather over the pixel; a late gate edge still counts
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      seen_norm <= 1'b0;
      seen_mult <= 1'b0;
    end else if (shift) begin
      seen_norm <= LINK.switch_gate_normal_path;
      seen_mult <= LINK.switch_gate_mult_path;
    end else begin
      seen_norm <= seen_norm | LINK.switch_gate_normal_path;
      seen_mult <= seen_mult | LINK.switch_gate_mult_path;
    end
  end

  // Horizontal register: one stage per entry, head fed by the charge source
  genvar gi;
  generate
    for (gi = 0; gi < HCCD_STAGES; gi++) begin : g_chain
      always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
          chain[gi] <= '0;
        end else if (shift) begin
          chain[gi] <= (gi == 0) ? I_CHARGE : chain[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  // Normal path: four more stages after the switch
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < NORM_STAGES; i++) begin
        nrm[i] <= '0;
      end
      norm_out <= '0;
    end else if (shift) begin
      nrm[0] <= seen_norm ? chain[HCCD_STAGES-1] : '0;
      for (int i = 1; i < NORM_STAGES; i++) begin
        nrm[i] <= nrm[i-1];
      end
      norm_out <= nrm[NORM_STAGES-1];
    end
  end

  // Multiplying register as a ring: a packet leaves one full line later
  always_ff @(posedge I_CLK) begin
    if (shift) begin
      em_mem[em_ptr] <= seen_mult ? chain[HCCD_STAGES-1] : '0;
    end
  end

  assign gain_prod = em_mem[em_ptr] * (CHARGE_W+8)'(MULT_GAIN);

  // Pointer and output; cells read as empty until written once
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      em_ptr   <= '0;
      em_full  <= 1'b0;
      mult_out <= '0;
    end else if (shift) begin
      if (!em_full) begin
        mult_out <= '0;
      end else if (|gain_prod[CHARGE_W+7:CHARGE_W]) begin
        mult_out <= '1;                                                // Saturate
      end else begin
        mult_out <= gain_prod[CHARGE_W-1:0];
      end
      if (em_ptr == EM_W'(EM_DEPTH - 1)) begin
        em_ptr  <= '0;
        em_full <= 1'b1;
      end else begin
        em_ptr <= em_ptr + 1'b1;
      end
    end
  end

  // The last step of a line lands with the row start, so it is added here
  assign line_total = line_cnt + CNT_W'(shift);

  // Line length check, done at each new row transfer. The mode is the one
  // latched when the ending line began, since the user may change it at any time.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      line_cnt    <= '0;
      line_split  <= 1'b0;
      O_ALIGN_ERR <= 1'b0;
    end else begin
      if (LINK.row_transfer && !row_q) begin
        line_cnt   <= '0;
        line_split <= I_SPLIT;
        if (line_total != '0 &&
            line_total != (line_split ? CNT_W'(LINE_SPLIT) : CNT_W'(LINE_FULL))) begin
          O_ALIGN_ERR <= 1'b1;
        end else if (I_ERR_CLR) begin
          O_ALIGN_ERR <= 1'b0;
        end
      end else begin
        if (shift) begin
          line_cnt <= line_cnt + 1'b1;
        end
        if (I_ERR_CLR) begin
          O_ALIGN_ERR <= 1'b0;
        end
      end
    end
  end

  // Gate order and parking watch; a new fault wins over a clear
  assign order_bad = (gate_now[2] & ~gate_q[2] & ~gate_q[3]) |
                     (gate_now[0] & ~gate_q[0] & ~gate_q[1]) |
                     (~gate_now[3] & gate_q[3] & gate_q[2]) |
                     (~gate_now[1] & gate_q[1] & gate_q[0]);
  assign park_bad  = LINK.row_transfer &
                     ((gate_now != PARK_GATES) | LINK.last_horizontal_gate |
                      LINK.switch_gate_normal_path | LINK.switch_gate_mult_path);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ORDER_ERR <= 1'b0;
      O_PARK_ERR  <= 1'b0;
      O_ROUTE_ERR <= 1'b0;
    end else begin
      O_ORDER_ERR <= order_bad | (O_ORDER_ERR & ~I_ERR_CLR);
      O_PARK_ERR  <= park_bad | (O_PARK_ERR & ~I_ERR_CLR);
      O_ROUTE_ERR <= (shift & (seen_norm == seen_mult)) | (O_ROUTE_ERR & ~I_ERR_CLR);
    end
  end

endmodule // emrt_sensor_quad

// ### hw/emrt_timing_gen.sv
// Camera timing generator end: row transfer, pixel gate sequence, route choice.
// Assumes the sensor end digitises its sense output into the link sample word,
// stable from the third clock of each pixel onward.
`timescale 1ns/1ps
module emrt_timing_gen import emrt_pkg::*; (
  // Clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RST,
  // Link
  emrt_link_if.gen                 LINK,
  // User control
  input  wire logic                I_RUN,
  input  wire logic                I_SPLIT,
  input  wire logic [CHARGE_W-1:0] I_THRESH,
  // User status
  output      logic                O_BUSY,
  output      logic                O_CLAMP,
  output      logic                O_LINE_DONE,
  output      logic                O_ROUTE_MULT,
  output      logic [CNT_W-1:0]    O_PIX_NUM
);

  emrt_state_e         state;                     // Sequencer state
  logic [TICK_W-1:0]   tick;                      // Clock within pixel
  logic [ROW_W-1:0]    row_cnt;                   // Clock within row transfer
  logic [CNT_W-1:0]    pix_cnt;                   // Pixels done in this line
  logic [CNT_W-1:0]    line_len;                  // Pixels per line for the mode
  logic [CHARGE_W-1:0] thresh;                    // Threshold held for the line
  logic [ROUTE_DELAY-1:0] route_sr;               // Decisions waiting for the switch
  logic [3:0]          seq_q;                     // Registered multiplier gates
  logic                lhg_q;                     // Registered phase two
  logic                sw_norm_q;                 // Registered normal switch gate
  logic                sw_mult_q;                 // Registered multiplier switch gate
  logic                row_xfer_q;                // Registered row transfer
  logic [3:0]          next_seq;
  logic                next_lhg;
  logic                next_sw_norm;
  logic                next_sw_mult;
  logic                pix_end;                   // Last clock of a pixel
  logic                line_end;                  // Last clock of a line
  logic [CNT_W-1:0]    mode_len;                  // Line length for the requested mode

  assign pix_end  = (state == ST_LINE) && (tick == TICK_LAST);
  assign line_end = pix_end && (pix_cnt == line_len - 1'b1);
  // Line length must not change inside a line, so it is taken per row
  assign mode_len = (I_SPLIT == MODE_SPLIT) ? CNT_W'(LINE_SPLIT)
                                            : CNT_W'(LINE_FULL);

  // Link drive, all from flip-flops
  assign LINK.row_transfer            = row_xfer_q;
  assign LINK.mult_store_gate_a       = seq_q[3];
  assign LINK.mult_barrier_gate_a     = seq_q[2];
  assign LINK.mult_store_gate_b       = seq_q[1];
  assign LINK.mult_barrier_gate_b     = seq_q[0];
  assign LINK.last_horizontal_gate    = lhg_q;
  assign LINK.switch_gate_normal_path = sw_norm_q;
  assign LINK.switch_gate_mult_path   = sw_mult_q;
  assign O_ROUTE_MULT = route_sr[ROUTE_DELAY-1];
  assign O_PIX_NUM    = pix_cnt;

  // Sequencer: idle, row transfer, then exactly one line of pixels
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state    <= ST_IDLE;
      tick     <= '0;
      row_cnt  <= '0;
      pix_cnt  <= '0;
      line_len <= CNT_W'(LINE_FULL);
      thresh   <= CHARGE_W'(THRESH_DEFAULT);
    end else begin
      case (state)
        ST_IDLE: begin
          // Mode and threshold latch at the start of every row
          if (I_RUN) begin
            state    <= ST_ROW;
            row_cnt  <= '0;
            line_len <= mode_len;
            thresh   <= I_THRESH;
          end
        end
        ST_ROW: begin
          if (row_cnt == ROW_LAST) begin
            state   <= ST_LINE;
            tick    <= '0;
            pix_cnt <= '0;
          end else begin
            row_cnt <= row_cnt + 1'b1;
          end
        end
        ST_LINE: begin
          if (line_end) begin
            // Stopping only between lines keeps the multiplier aligned
            tick    <= '0;
            pix_cnt <= '0;
            row_cnt <= '0;
            if (I_RUN) begin
              state    <= ST_ROW;
              line_len <= mode_len;
              thresh   <= I_THRESH;
            end else begin
              state <= ST_IDLE;
            end
          end else if (pix_end) begin
            tick    <= '0;
            pix_cnt <= pix_cnt + 1'b1;
          end else begin
            tick <= tick + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Route decision per packet; small packets go to the multiplier.
  // The chain holds across row transfers because the packets in flight
  // freeze there too.
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      route_sr <= '0;
    end else if (state == ST_LINE && tick == SAMPLE_TICK) begin
      route_sr <= {route_sr[ROUTE_DELAY-2:0],
                   (LINK.threshold_sense_output < thresh)};
    end
  end

  // Gate pattern for the present tick
  always_comb begin
    next_seq     = PARK_GATES;
    next_lhg     = 1'b0;
    next_sw_norm = 1'b0;
    next_sw_mult = 1'b0;
    if (state == ST_LINE) begin
      // Barriers rise only on a high store and fall ahead of it, barrier b one tick, barrier a four ticks
      next_seq = GATE_SEQ[tick];
      if (tick >= LHG_ON_TICK) begin
        next_lhg = 1'b1;
        // Oldest decision is the packet now sitting at the switch
        next_sw_mult = route_sr[ROUTE_DELAY-1];
        next_sw_norm = ~route_sr[ROUTE_DELAY-1];
      end
    end
  end

  // Gate registers; one clock behind the sequencer for every signal alike
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      seq_q      <= PARK_GATES;
      lhg_q      <= 1'b0;
      sw_norm_q  <= 1'b0;
      sw_mult_q  <= 1'b0;
      row_xfer_q <= 1'b0;
    end else begin
      seq_q      <= next_seq;
      lhg_q      <= next_lhg;
      sw_norm_q  <= next_sw_norm;
      sw_mult_q  <= next_sw_mult;
      row_xfer_q <= (state == ST_ROW);
    end
  end

  // User status
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BUSY      <= 1'b0;
      O_CLAMP     <= 1'b0;
      O_LINE_DONE <= 1'b0;
    end else begin
      O_BUSY      <= (state != ST_IDLE);
      // Clamp window covers the dummy pixels at line start only
      O_CLAMP     <= (state == ST_LINE) && (pix_cnt < CNT_W'(CLAMP_CYCLES));
      O_LINE_DONE <= line_end;
    end
  end

endmodule // emrt_timing_gen

// ### sim/emrt_link_monitor.sv
// Link checker: gate order, parking, pixel shape and line length.
// Assumes it sits beside the link, fed with its gate signals.
`timescale 1ns/1ps
module emrt_link_monitor import emrt_pkg::*; (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // Generator gates
  input wire logic row_transfer,
  input wire logic mult_store_gate_a,
  input wire logic mult_barrier_gate_a,
  input wire logic mult_store_gate_b,
  input wire logic mult_barrier_gate_b,
  input wire logic last_horizontal_gate,
  input wire logic switch_gate_normal_path,
  input wire logic switch_gate_mult_path
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  int   steps;  // Steps in this line; a row transfer clears it
  logic lhg_q;  // Phase two one clock back, for step detection
  // The last step may land with the row start, so the check adds it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      steps <= 0;
      lhg_q <= 1'b0;
    end else begin
      lhg_q <= last_horizontal_gate;
      if (row_transfer) steps <= 0;
      else if (lhg_q && !last_horizontal_gate) steps <= steps + 1;
    end
  end
  sequence pix_high_s; last_horizontal_gate [*4]; endsequence
  sequence pix_low_s; !last_horizontal_gate [*4]; endsequence
  sequence one_route_s; (switch_gate_normal_path ^ switch_gate_mult_path) [*4]; endsequence
  park_gates_a: assert property (row_transfer |-> mult_store_gate_a &&
    mult_barrier_gate_a && !mult_store_gate_b && !mult_barrier_gate_b &&
    !last_horizontal_gate && !switch_gate_normal_path && !switch_gate_mult_path)
    else $error("gates not parked in row transfer");
  barrier_rise_a: assert property (1'b1 |->
    (!$rose(mult_barrier_gate_a) || $past(mult_store_gate_a)) &&
    (!$rose(mult_barrier_gate_b) || $past(mult_store_gate_b)))
    else $error("barrier rose before its store");
  barrier_fall_a: assert property (1'b1 |->
    (!$fell(mult_store_gate_a) || !$past(mult_barrier_gate_a)) &&
    (!$fell(mult_store_gate_b) || !$past(mult_barrier_gate_b)))
    else $error("store fell before its barrier");
  store_swap_a: assert property ($fell(mult_store_gate_b) |->
    $rose(mult_store_gate_a) && !mult_barrier_gate_b) else $error("store swap broken");
  route_onehot_a: assert property ($rose(last_horizontal_gate) |-> one_route_s)
    else $error("not one switch gate per pixel");
  route_idle_a: assert property ((switch_gate_normal_path || switch_gate_mult_path)
    |-> last_horizontal_gate) else $error("switch gate outside phase two");
  pixel_period_a: assert property ($rose(last_horizontal_gate) |->
    pix_high_s ##1 pix_low_s) else $error("pixel period too short");
  line_length_a: assert property ($rose(row_transfer) |->
    (steps + int'($fell(last_horizontal_gate))) inside {0, LINE_FULL, LINE_SPLIT})
    else $error("wrong step count in line");
endmodule // emrt_link_monitor

// ### sim/tb.sv
// Bench: generator and sensor joined by the link, full then split lines.
// Assumes package figures; the charge pattern alternates small and large.
`timescale 1ns/1ps
module tb;
  import emrt_pkg::*;
  localparam int GAIN = 4;                  // Gain given to the sensor
  logic clk = 0, rst = 1, run = 0, split = 0, err_clr = 0;
  logic skew = 0;                           // Skews the sensor's mode to force an error
  logic [CHARGE_W-1:0] thresh = CHARGE_W'(THRESH_DEFAULT);
  logic [CHARGE_W-1:0] charge = 16'h0010;   // Packet for step one
  logic busy, clamp, done, rmult, shift, shifted = 0;
  logic align_err, order_err, park_err, route_err;
  logic [CNT_W-1:0] pix;
  int err_total = 0, total_checks = 0;
  int g = 0, cyc = 0, clamp_cyc = 0, dones = 0, gb = 0, x, y, z;
  emrt_link_if link ();
  emrt_timing_gen emrt_timing_gen_i (.I_CLK(clk), .I_RST(rst), .LINK(link.gen),
    .I_RUN(run), .I_SPLIT(split), .I_THRESH(thresh), .O_BUSY(busy), .O_CLAMP(clamp),
    .O_LINE_DONE(done), .O_ROUTE_MULT(rmult), .O_PIX_NUM(pix));
  emrt_sensor_quad #(.MULT_GAIN(GAIN)) emrt_sensor_quad_i (.I_CLK(clk), .I_RST(rst),
    .LINK(link.dev), .I_CHARGE(charge), .I_SPLIT(split ^ skew), .I_ERR_CLR(err_clr),
    .O_SHIFT(shift), .O_ALIGN_ERR(align_err), .O_ORDER_ERR(order_err),
    .O_PARK_ERR(park_err), .O_ROUTE_ERR(route_err));
  emrt_link_monitor emrt_link_monitor_i (.I_CLK(clk), .I_RST(rst),
    .row_transfer(link.row_transfer), .mult_store_gate_a(link.mult_store_gate_a),
    .mult_barrier_gate_a(link.mult_barrier_gate_a),
    .mult_store_gate_b(link.mult_store_gate_b),
    .mult_barrier_gate_b(link.mult_barrier_gate_b),
    .last_horizontal_gate(link.last_horizontal_gate),
    .switch_gate_normal_path(link.switch_gate_normal_path),
    .switch_gate_mult_path(link.switch_gate_mult_path));
  initial forever #50 clk = ~clk;           // 10 MHz
  // Odd steps carry small packets, even steps large ones; none before step one
  function automatic logic [CHARGE_W-1:0] pat(input int n);
    return (n < 1) ? 16'h0000 : (n[0] ? 16'h0010 : 16'h1000);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for line ends; a full line of 24688 cycles is well under the 30000 bound
  task automatic wait_done(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin @(negedge clk); k++; end while (done !== 1'b1 && k < 30000);
      if (k >= 30000) begin
        err_total++;
        $display("[FAIL] %0t line end timeout", $time);
        summarize();
      end
    end
  endtask
  // New packet at every step, indexed by the global step count
  always @(posedge clk) begin
    shifted <= shift;
    if (shift === 1'b1) begin
      g <= g + 1;
      charge <= pat(g + 2);
    end
  end
  // Outputs settle on the step edge; look half a cycle later
  always @(negedge clk) if (shifted === 1'b1) begin
    x = g - NORMAL_DELAY + 1;
    y = g - MULT_DELAY - LINE_FULL + 1;
    z = g - SENSE_DELAY - ROUTE_DELAY + 1;
    // Oldest decision belongs to the packet sensed 28 pixels back
    chk(rmult, (g < ROUTE_DELAY) ? 1'b0 : (z < 1 || z[0]));
    chk(pix, g - gb);
    chk(link.threshold_sense_output, pat(g - SENSE_DELAY + 1));
    chk(link.normal_gain_output, (x >= 1 && !x[0]) ? 16'h1000 : 16'h0000);
    chk(link.multiplied_output, (y >= 1 && y[0]) ? 16*GAIN : 0);
  end
  // Per line: clamp width and period; the first line starts from idle
  always @(posedge clk) begin
    cyc <= (done === 1'b1) ? 1 : cyc + 1;
    clamp_cyc <= ((done === 1'b1) ? 0 : clamp_cyc) + int'(clamp === 1'b1);
    if (done === 1'b1) begin
      dones <= dones + 1;
      gb <= g + 1;
      chk(clamp_cyc, CLAMP_CYCLES * PIX_TICKS);
      if (dones > 0)
        chk(cyc, ROW_XFER_TICKS + ((dones < 2) ? LINE_FULL : LINE_SPLIT) * PIX_TICKS);
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    run <= 1;
    wait_done(1);
    chk(busy, 1);
    // Mode changes mid-line; the sensor is skewed so its check of line 3 trips
    repeat (20) @(posedge clk);
    split <= 1;
    skew <= 1;
    wait_done(2);
    @(posedge clk);
    run <= 0;
    wait_done(1);
    $display("stream test done");
    repeat (3) @(negedge clk);
    chk(busy, 0);
    chk({align_err, order_err, park_err, route_err}, 4'h8);
    @(posedge clk);
    err_clr <= 1;
    @(posedge clk);
    err_clr <= 0;
    @(negedge clk);
    chk({align_err, order_err, park_err, route_err}, 0);
    $display("status test done");
    summarize();
  end
endmodule // tb
